// File: inc/clock_switch_pkg.sv
// constants, field layouts and command codes of the clock switch and prescaler
// assumes a byte-wide register port and one 100 MHz clock
package clock_switch_pkg;

   // ---------------------------------------------------------------
   // register port
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;

   localparam logic [ADDR_W-1:0] OFF_SYSTEM_CLOCK_DIVIDER    = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_CLOCK_COMMAND_STATUS    = 8'h01;
   localparam logic [ADDR_W-1:0] OFF_CLOCK_SOURCE_SELECTION  = 8'h02;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned POS_CHANGE_ENABLE = 7;
   localparam int unsigned POS_READY         = 4;
   localparam int unsigned POS_OUTPUT_BIT    = 6;
   localparam int unsigned POS_STARTUP_LO    = 4;
   localparam int unsigned POS_STARTUP_HI    = 5;
   localparam int unsigned POS_SOURCE_HI     = 3;

   localparam logic [DATA_W-1:0] CHANGE_ENABLE_ONLY = 8'h80;

   // ---------------------------------------------------------------
   // reset values and top prescale code
   // ---------------------------------------------------------------
   localparam logic [3:0] PRESCALE_RESET_PLAIN = 4'h0;
   localparam logic [3:0] PRESCALE_RESET_DIV8  = 4'h3;
   localparam logic [3:0] COMMAND_RESET        = 4'h0;
   localparam logic [3:0] PRESCALE_MAX_CODE    = 4'h8;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLOCK_MHZ          = 100;
   localparam int unsigned CHANGE_WINDOW      = 4;
   localparam logic [2:0]  CHANGE_WINDOW_LOAD = 3'(CHANGE_WINDOW);
   // settle time for the synchronised availability level after a request
   localparam int unsigned READY_HOLDOFF      = 4;
   localparam logic [2:0]  READY_HOLDOFF_LOAD = 3'(READY_HOLDOFF);

   // ---------------------------------------------------------------
   // commands
   // ---------------------------------------------------------------
   typedef enum logic [3:0] {
      CMD_NONE          = 4'h0,
      CMD_DISABLE       = 4'h1,
      CMD_ENABLE        = 4'h2,
      CMD_AVAIL_REQUEST = 4'h3,
      CMD_SWITCH        = 4'h4,
      CMD_RECOVER       = 4'h5,
      CMD_WDOG_RELOAD   = 4'h6,
      CMD_CLOCK_OUTPUT  = 4'h7
   } clock_command_t;

endpackage

// File: src/clock_switch_prescaler.sv
// system clock prescaler, protected clock command register and source selection
// assumes fuse inputs are static while running; availability confirm is asynchronous
`timescale 1ns/1ps

module clock_switch_prescaler (
   input  wire logic                              mclk,
   input  wire logic                              rst,
   input  wire logic [clock_switch_pkg::ADDR_W-1:0] addr,
   input  wire logic [clock_switch_pkg::DATA_W-1:0] wdata,
   input  wire logic                              wr,
   input  wire logic                              rd,
   output      logic [clock_switch_pkg::DATA_W-1:0] rdata,
   input  wire logic                              divide_by_eight_fuse,
   input  wire logic                              output_buffer_fuse,
   input  wire logic [1:0]                        startup_fuses,
   input  wire logic [3:0]                        source_select_fuses,
   input  wire logic                              availability_confirm,
   input  wire logic [3:0]                        current_source,
   input  wire logic                              watchdog_enable,
   output      logic                              system_clock_enable,
   output      logic                              command_valid,
   output      logic [3:0]                        command_code,
   output      logic [3:0]                        command_source,
   output      logic [1:0]                        command_startup,
   output      logic                              command_output_bit,
   output      logic                              watchdog_auto_reload,
   output      logic                              watchdog_reset_enable,
   output      logic                              watchdog_interrupt_enable
);
   import clock_switch_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   logic [3:0] prescale_select;
   logic       prescale_change_enable;
   logic [2:0] prescale_window;
   logic       command_change_enable;
   logic [2:0] command_window;
   logic [3:0] command_field;
   logic       source_ready_flag;
   logic       ready_armed;
   logic [2:0] ready_holdoff;
   logic       output_buffer_bit;
   logic [1:0] startup_time_field;
   logic [3:0] source_select_field;
   logic [7:0] divide_count;
   logic [7:0] divide_limit;
   logic [2:0] avail_sync;
   logic       avail_stable;

   // ---------------------------------------------------------------
   // access decode
   // ---------------------------------------------------------------
   logic wr_divider;
   logic wr_command;
   logic wr_selection;
   logic unlock_pattern;
   logic prescale_take;
   logic command_take;
   clock_command_t new_command;

   assign wr_divider     = wr && (addr == OFF_SYSTEM_CLOCK_DIVIDER);
   assign wr_command     = wr && (addr == OFF_CLOCK_COMMAND_STATUS);
   assign wr_selection   = wr && (addr == OFF_CLOCK_SOURCE_SELECTION);
   assign unlock_pattern = (wdata == CHANGE_ENABLE_ONLY);
   // data write: unlock pending and change-enable written zero
   assign prescale_take  = wr_divider && prescale_change_enable && !wdata[POS_CHANGE_ENABLE];
   assign command_take   = wr_command && command_change_enable && !wdata[POS_CHANGE_ENABLE];
   assign new_command    = clock_command_t'(wdata[3:0]);

   // ---------------------------------------------------------------
   // prescaler unlock and select
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         prescale_change_enable <= 1'b0;
         prescale_window        <= 3'h0;
      end else if (prescale_take) begin
         prescale_change_enable <= 1'b0;
         prescale_window        <= 3'h0;
      end else if (prescale_change_enable) begin
         // rewrite of the unlock pattern is ignored while counting
         if (prescale_window == 3'h1) begin
            prescale_change_enable <= 1'b0;
         end
         prescale_window <= prescale_window - 3'h1;
      end else if (wr_divider && unlock_pattern) begin
         prescale_change_enable <= 1'b1;
         prescale_window        <= CHANGE_WINDOW_LOAD;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         prescale_select <= divide_by_eight_fuse ? PRESCALE_RESET_DIV8 : PRESCALE_RESET_PLAIN;
      end else if (prescale_take) begin
         prescale_select <= wdata[3:0];
      end
   end

   // ---------------------------------------------------------------
   // divider: one enable pulse per divided period
   // ---------------------------------------------------------------
   // reserved codes run at the slowest rate
   always_comb begin
      if (prescale_select >= PRESCALE_MAX_CODE) begin
         divide_limit = 8'hff;
      end else begin
         divide_limit = 8'((9'h001 << prescale_select) - 9'h001);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         divide_count        <= 8'h00;
         system_clock_enable <= 1'b0;
      end else if (prescale_take) begin
         // restart so the period spanning the change is no shorter than the new setting
         divide_count        <= 8'h00;
         system_clock_enable <= 1'b0;
      end else if (divide_count >= divide_limit) begin
         divide_count        <= 8'h00;
         system_clock_enable <= 1'b1;
      end else begin
         divide_count        <= divide_count + 8'h01;
         system_clock_enable <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // command unlock and command field
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         command_change_enable <= 1'b0;
         command_window        <= 3'h0;
      end else if (command_take) begin
         command_change_enable <= 1'b0;
         command_window        <= 3'h0;
      end else if (command_change_enable) begin
         if (command_window == 3'h1) begin
            command_change_enable <= 1'b0;
         end
         command_window <= command_window - 3'h1;
      end else if (wr_command && unlock_pattern) begin
         command_change_enable <= 1'b1;
         command_window        <= CHANGE_WINDOW_LOAD;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         command_field <= COMMAND_RESET;
      end else if (command_take) begin
         command_field <= wdata[3:0];
      end
   end

   // ---------------------------------------------------------------
   // command issue towards the switch logic
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         command_valid      <= 1'b0;
         command_code       <= COMMAND_RESET;
         command_source     <= 4'h0;
         command_startup    <= 2'h0;
         command_output_bit <= 1'b0;
      end else begin
         command_valid <= 1'b0;
         if (command_take && !wdata[3] && (new_command != CMD_NONE)) begin
            command_valid      <= 1'b1;
            command_code       <= wdata[3:0];
            command_source     <= source_select_field;
            command_startup    <= startup_time_field;
            command_output_bit <= output_buffer_bit;
         end
      end
   end

   // ---------------------------------------------------------------
   // selection register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         output_buffer_bit <= ~output_buffer_fuse;
      end else if (wr_selection) begin
         output_buffer_bit <= wdata[POS_OUTPUT_BIT];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         startup_time_field <= startup_fuses;
      end else if (wr_selection) begin
         startup_time_field <= wdata[POS_STARTUP_HI:POS_STARTUP_LO];
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         source_select_field <= source_select_fuses;
      end else if (command_take && (new_command == CMD_RECOVER)) begin
         source_select_field <= current_source;
      end else if (wr_selection) begin
         source_select_field <= wdata[POS_SOURCE_HI:0];
      end
   end

   // ---------------------------------------------------------------
   // availability synchroniser and ready flag
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         avail_sync   <= 3'h0;
         avail_stable <= 1'b0;
      end else begin
         avail_sync <= {avail_sync[1:0], availability_confirm};
         if (avail_sync[2] == avail_sync[1]) begin
            avail_stable <= avail_sync[1];
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         source_ready_flag <= 1'b0;
         ready_armed       <= 1'b0;
         ready_holdoff     <= 3'h0;
      end else if (command_take &&
                   ((new_command == CMD_AVAIL_REQUEST) || (new_command == CMD_ENABLE))) begin
         source_ready_flag <= 1'b0;
         ready_armed       <= 1'b1;
         ready_holdoff     <= READY_HOLDOFF_LOAD;
      end else if (ready_holdoff != 3'h0) begin
         // stale confirm still in flight through the synchroniser
         ready_holdoff <= ready_holdoff - 3'h1;
      end else if (ready_armed && avail_stable) begin
         source_ready_flag <= 1'b1;
         ready_armed       <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // watchdog automatic reload
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         watchdog_auto_reload <= 1'b0;
      end else if (command_take && (new_command == CMD_WDOG_RELOAD)) begin
         watchdog_auto_reload <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         watchdog_reset_enable     <= 1'b0;
         watchdog_interrupt_enable <= 1'b0;
      end else begin
         // auto reload forces reset-only watchdog
         watchdog_reset_enable     <= watchdog_enable || watchdog_auto_reload;
         watchdog_interrupt_enable <= watchdog_enable && !watchdog_auto_reload;
      end
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (rst) begin
         rdata <= 8'h00;
      end else if (rd) begin
         case (addr)
            OFF_SYSTEM_CLOCK_DIVIDER: begin
               rdata <= {prescale_change_enable, 3'h0, prescale_select};
            end
            OFF_CLOCK_COMMAND_STATUS: begin
               rdata <= {command_change_enable, 2'h0, source_ready_flag, command_field};
            end
            OFF_CLOCK_SOURCE_SELECTION: begin
               rdata <= {1'b0, output_buffer_bit, startup_time_field, source_select_field};
            end
            default: begin
               rdata <= 8'h00;
            end
         endcase
      end else begin
         rdata <= 8'h00;
      end
   end

endmodule

// File: tb/clock_switch_asserts.sv
// checker for the register port, command and watchdog outputs of the clock switch
// assumes it is bound onto clock_switch_prescaler, one clock domain, synchronous reset
`timescale 1ns/1ps
module clock_switch_asserts (
   input  wire logic                                mclk,
   input  wire logic                                rst,
   input  wire logic [clock_switch_pkg::ADDR_W-1:0] addr,
   input  wire logic [clock_switch_pkg::DATA_W-1:0] wdata,
   input  wire logic                                wr,
   input  wire logic                                rd,
   input  wire logic [clock_switch_pkg::DATA_W-1:0] rdata,
   input  wire logic                                command_valid,
   input  wire logic [3:0]                          command_code,
   input  wire logic                                watchdog_auto_reload,
   input  wire logic                                watchdog_reset_enable,
   input  wire logic                                watchdog_interrupt_enable,
   input  wire logic                                system_clock_enable
);
   import clock_switch_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // unlock window model
   // ---------------------------------------------------------------
   logic [2:0] win;
   logic       cmd_hit;
   logic       cmd_wr;
   assign cmd_hit = wr && addr == OFF_CLOCK_COMMAND_STATUS;
   assign cmd_wr  = cmd_hit && wdata[7:3] == 5'h00 && wdata[2:0] != 3'h0;
   always_ff @(posedge mclk) begin
      if (rst) begin
         win <= 3'h0;
      end else if (cmd_hit && wdata == CHANGE_ENABLE_ONLY && win == 3'h0) begin
         win <= CHANGE_WINDOW_LOAD;
      end else if (win != 3'h0) begin
         win <= (cmd_hit && !wdata[7]) ? 3'h0 : win - 3'h1;
      end
   end

   // ---------------------------------------------------------------
   // properties
   // ---------------------------------------------------------------
   a_cmd_accepted: assert property (cmd_wr && win != 3'h0 |=> command_valid && command_code == $past(wdata[3:0]))
      else $error("command in window not issued");
   a_cmd_refused: assert property (cmd_wr && win == 3'h0 |=> !command_valid)
      else $error("command outside window issued");
   a_no_cmd_silent: assert property (cmd_hit && !cmd_wr |=> !command_valid)
      else $error("no-command write issued a command");
   a_valid_once: assert property (command_valid |=> !command_valid)
      else $error("command pulse longer than one cycle");
   a_reserved_zero: assert property (rd |=> ($past(addr) != 8'h00 || rdata[6:4] == 3'h0)
      && ($past(addr) != 8'h01 || rdata[6:5] == 2'h0) && ($past(addr) != 8'h02 || !rdata[7]))
      else $error("reserved bit read as one");
   a_wdog_start: assert property (command_valid && command_code == CMD_WDOG_RELOAD |-> watchdog_auto_reload)
      else $error("auto reload not started");
   a_wdog_sticky: assert property (watchdog_auto_reload |=> watchdog_auto_reload)
      else $error("auto reload dropped without reset");
   a_wdog_mode: assert property (watchdog_auto_reload |=> watchdog_reset_enable && !watchdog_interrupt_enable)
      else $error("auto reload left interrupt on or reset off");

   c_command: cover property (command_valid);
   c_wdog: cover property ($rose(watchdog_auto_reload));
   c_ready: cover property (rd && addr == 8'h01 ##1 rdata[4]);
   c_divider: cover property (system_clock_enable ##1 !system_clock_enable);
endmodule

bind clock_switch_prescaler clock_switch_asserts u_chk (
   .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .command_valid(command_valid), .command_code(command_code), .watchdog_auto_reload(watchdog_auto_reload),
   .watchdog_reset_enable(watchdog_reset_enable), .watchdog_interrupt_enable(watchdog_interrupt_enable),
   .system_clock_enable(system_clock_enable));

// File: tb/tb_top.sv
// self-checking bench for the clock switch and prescaler
// assumes a 100 MHz clock and static fuses between resets
`timescale 1ns/1ps
module tb_top;
   import clock_switch_pkg::*;
   typedef struct packed {logic [3:0] pre; logic [8:0] gap; logic [3:0] code; logic valid;} row_t;
   logic       mclk, rst, wr, rd, div8, obf, confirm, wd_en;
   logic       sce, cv, cob, war, wre, wie;
   logic [7:0] addr, wdata, rdata, v;
   logic [1:0] sut, cst;
   logic [3:0] ssf, cur, cc, cs;
   int         err_total, total_checks;
   // prescale code, enable spacing, command code, pulse expected; code 9 runs at the slowest rate
   row_t       rows [10] = '{'{4'h0, 9'h001, 4'h0, 1'b0}, '{4'h1, 9'h002, 4'h1, 1'b1},
                             '{4'h2, 9'h004, 4'h2, 1'b1}, '{4'h3, 9'h008, 4'h3, 1'b1},
                             '{4'h4, 9'h010, 4'h4, 1'b1}, '{4'h5, 9'h020, 4'h5, 1'b1},
                             '{4'h6, 9'h040, 4'h7, 1'b1}, '{4'h7, 9'h080, 4'h8, 1'b0},
                             '{4'h8, 9'h100, 4'hf, 1'b0}, '{4'h9, 9'h100, 4'ha, 1'b0}};

   clock_switch_prescaler DUT (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .divide_by_eight_fuse(div8), .output_buffer_fuse(obf), .startup_fuses(sut),
      .source_select_fuses(ssf), .availability_confirm(confirm), .current_source(cur), .watchdog_enable(wd_en),
      .system_clock_enable(sce), .command_valid(cv), .command_code(cc), .command_source(cs),
      .command_startup(cst), .command_output_bit(cob), .watchdog_auto_reload(war),
      .watchdog_reset_enable(wre), .watchdog_interrupt_enable(wie));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task check(input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   task rd_reg(input logic [7:0] a, output logic [7:0] q);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      @(negedge mclk);
      q = rdata;
   endtask
   task cmd(input logic [3:0] c);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, CHANGE_ENABLE_ONLY);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, {4'h0, c});
      @(negedge mclk);
   endtask
   // spacing between two enable pulses
   task gap_chk(input int exp);
      int k;
      k = 0;
      @(negedge mclk);
      while (sce !== 1'b1 && k < 600) begin
         @(negedge mclk);
         k++;
      end
      k = 0;
      do begin
         @(negedge mclk);
         k++;
      end while (sce !== 1'b1 && k < 600);
      check(12'(k), 12'(exp));
   endtask
   task wrap_up;
      if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #100us;
      err_total++;
      wrap_up();
   end

   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      {rst, wr, rd, addr, wdata, div8, obf, sut, ssf} = {3'b100, 16'h0, 2'b10, 2'h2, 4'h5};
      {confirm, cur, wd_en} = {1'b0, 4'h5, 1'b1};
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(OFF_SYSTEM_CLOCK_DIVIDER, v);
      check(12'(v), 12'h003);
      rd_reg(OFF_CLOCK_SOURCE_SELECTION, v);
      check(12'(v), 12'h065);
      rd_reg(8'h07, v);
      check(12'(v), 12'h000);
      gap_chk(8);
      wr_reg(OFF_CLOCK_SOURCE_SELECTION, 8'he5);
      rd_reg(OFF_CLOCK_SOURCE_SELECTION, v);
      check(12'(v), 12'h065);
      foreach (rows[i]) begin
         wr_reg(OFF_SYSTEM_CLOCK_DIVIDER, CHANGE_ENABLE_ONLY);
         wr_reg(OFF_SYSTEM_CLOCK_DIVIDER, {4'h0, rows[i].pre});
         rd_reg(OFF_SYSTEM_CLOCK_DIVIDER, v);
         check(12'(v), 12'(rows[i].pre));
         gap_chk(rows[i].gap);
         cmd(rows[i].code);
         check(12'(cv), 12'(rows[i].valid));
         if (rows[i].valid) check(12'({cc, cs, cst, cob}), {1'b0, rows[i].code, 4'h5, 2'h2, 1'b1});
         rd_reg(OFF_CLOCK_COMMAND_STATUS, v);
         check(12'(v[3:0]), 12'(rows[i].code));
      end
      // unlock readback, then a rewrite that must not stretch the window
      wr_reg(OFF_SYSTEM_CLOCK_DIVIDER, CHANGE_ENABLE_ONLY);
      rd_reg(OFF_SYSTEM_CLOCK_DIVIDER, v);
      check(12'(v), 12'h089);
      wr_reg(OFF_SYSTEM_CLOCK_DIVIDER, CHANGE_ENABLE_ONLY);
      wr_reg(OFF_SYSTEM_CLOCK_DIVIDER, 8'h01);
      rd_reg(OFF_SYSTEM_CLOCK_DIVIDER, v);
      check(12'(v), 12'h009);
      rd_reg(OFF_CLOCK_COMMAND_STATUS, v);
      check(12'(v[4]), 12'h000);
      @(posedge mclk);
      confirm <= 1'b1;
      repeat (12) @(posedge mclk);
      rd_reg(OFF_CLOCK_COMMAND_STATUS, v);
      check(12'(v[4]), 12'h001);
      cmd(4'h3);
      rd_reg(OFF_CLOCK_COMMAND_STATUS, v);
      check(12'(v[4]), 12'h000);
      repeat (12) @(posedge mclk);
      rd_reg(OFF_CLOCK_COMMAND_STATUS, v);
      check(12'(v[4]), 12'h001);
      cmd(4'h2);
      rd_reg(OFF_CLOCK_COMMAND_STATUS, v);
      check(12'(v[4]), 12'h000);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, 8'h84);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, 8'h01);
      @(negedge mclk);
      check(12'(cv), 12'h000);
      // last accepted edge of the window, then the first refused one
      wr_reg(OFF_CLOCK_COMMAND_STATUS, CHANGE_ENABLE_ONLY);
      repeat (2) @(posedge mclk);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, 8'h04);
      @(negedge mclk);
      check(12'(cv), 12'h001);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, CHANGE_ENABLE_ONLY);
      repeat (3) @(posedge mclk);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, 8'h04);
      @(negedge mclk);
      check(12'(cv), 12'h000);
      // rewrite inside the window neither clears nor stretches it
      wr_reg(OFF_CLOCK_COMMAND_STATUS, CHANGE_ENABLE_ONLY);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, CHANGE_ENABLE_ONLY);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, 8'h04);
      @(negedge mclk);
      check(12'(cv), 12'h001);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, CHANGE_ENABLE_ONLY);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, CHANGE_ENABLE_ONLY);
      @(posedge mclk);
      wr_reg(OFF_CLOCK_COMMAND_STATUS, 8'h04);
      @(negedge mclk);
      check(12'(cv), 12'h000);
      @(posedge mclk);
      cur <= 4'ha;
      cmd(4'h5);
      rd_reg(OFF_CLOCK_SOURCE_SELECTION, v);
      check(12'(v), 12'h06a);
      check(12'({war, wie}), 12'h001);
      cmd(4'h6);
      @(negedge mclk);
      check(12'({war, wre, wie}), 12'h006);
      repeat (20) @(negedge mclk);
      check(12'(war), 12'h001);
      @(posedge mclk);
      div8 <= 1'b0;
      obf <= 1'b1;
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(negedge mclk);
      check(12'(war), 12'h000);
      rd_reg(OFF_SYSTEM_CLOCK_DIVIDER, v);
      check(12'(v), 12'h000);
      rd_reg(OFF_CLOCK_SOURCE_SELECTION, v);
      check(12'(v), 12'h025);
      wrap_up();
   end
endmodule
